// ---- verilog/wrc_pkg.sv ----
// shared types and constants of the wake, reset and direct input control
package wrc_pkg;

    // clock and time base
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned TICK_US       = 1000;
    localparam int unsigned TICK_CYC      = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned TICK_W        = 15;
    // direct input toggle timeout, least figure in ms
    localparam int unsigned T_IN_MIN_MS   = 175;
    localparam int unsigned T_IN_TICKS    = (T_IN_MIN_MS * 1000 + TICK_US - 1) / TICK_US;
    localparam int unsigned ACT_CNT_W     = 8;
    // least low time of the reset pin, kept by the host
    localparam int unsigned T_WRST_US     = 10;
    localparam int unsigned T_WRST_CYC    = (CLK_HZ / 1_000_000) * T_WRST_US;

    localparam int unsigned NUM_CH        = 4;
    localparam int unsigned PWM_CLK_CH    = 0;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_NORMAL,
        MODE_FAILSAFE
    } wrc_mode_t;

    // setting written over the serial port
    typedef struct packed {
        logic [3:0] spi_on;
        logic [3:0] direct_en;
        logic       pwm_en;
        logic       pwm_ext_clk;
        logic       sense_temp;
        logic [1:0] sense_chan;
        logic       sense_hiz;
    } wrc_cfg_t;

    localparam wrc_cfg_t CFG_RESET = '{
        spi_on:      4'h0,
        direct_en:   4'hf,
        pwm_en:      1'h0,
        pwm_ext_clk: 1'h0,
        sense_temp:  1'h0,
        sense_chan:  2'h0,
        sense_hiz:   1'h1
    };

    typedef struct packed {
        logic [3:0] oc;
        logic [3:0] ot;
        logic [3:0] sc;
        logic       uv;
        logic       ov;
    } wrc_fault_t;

    localparam wrc_fault_t FAULT_RESET = '0;

    typedef struct packed {
        logic       temp;
        logic [1:0] chan;
    } wrc_sense_t;

    // state of one input activity detector
    typedef struct packed {
        logic                 prev;
        logic [ACT_CNT_W-1:0] cnt;
        logic                 active;
    } wrc_act_state_t;

    localparam wrc_act_state_t ACT_RESET = '0;

    // state of the pin control block
    typedef struct packed {
        logic              rst_s1;
        logic              rst_s2;
        logic              rst_s3;
        logic              wake_s1;
        logic              wake_s2;
        logic [3:0]        din_s1;
        logic [3:0]        din_s2;
        logic [TICK_W-1:0] tick_cnt;
        logic              tick;
        wrc_mode_t         mode;
        wrc_cfg_t          cfg;
        wrc_fault_t        faults;
        logic [3:0]        power;
        wrc_sense_t        sense_sel;
        logic              sense_oe_n;
        logic              flag_oe_n;
        logic              wdog_start;
        logic              wdog_run;
        logic              pwm_clk;
    } wrc_state_t;

    localparam wrc_state_t STATE_RESET = '{
        rst_s1:     1'h0,
        rst_s2:     1'h0,
        rst_s3:     1'h0,
        wake_s1:    1'h0,
        wake_s2:    1'h0,
        din_s1:     4'h0,
        din_s2:     4'h0,
        tick_cnt:   15'h0000,
        tick:       1'h0,
        mode:       MODE_SLEEP,
        cfg:        CFG_RESET,
        faults:     FAULT_RESET,
        power:      4'h0,
        sense_sel:  3'h0,
        sense_oe_n: 1'h1,
        flag_oe_n:  1'h1,
        wdog_start: 1'h0,
        wdog_run:   1'h0,
        pwm_clk:    1'h0
    };

endpackage

// ---- verilog/wrc_in_activity.sv ----
// activity detector of one direct input: high level or recent toggle
`timescale 1ns/1ns
module wrc_in_activity #(
    parameter int unsigned TIMEOUT_TICKS = wrc_pkg::T_IN_TICKS
) (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    // time base and input
    input  wire logic tick_in,
    input  wire logic level_in,
    // result
    output logic      active_out
);

    // refused at elaboration: the reload value must fit the counter
    if (TIMEOUT_TICKS < 1 || TIMEOUT_TICKS >= (1 << wrc_pkg::ACT_CNT_W)) begin : g_bad_timeout
        $error("wrc_in_activity: TIMEOUT_TICKS out of range");
    end

    localparam logic [wrc_pkg::ACT_CNT_W-1:0] RELOAD = wrc_pkg::ACT_CNT_W'(TIMEOUT_TICKS);

    wrc_pkg::wrc_act_state_t st;
    wrc_pkg::wrc_act_state_t next_st;

    always_comb begin
        next_st      = st;
        next_st.prev = level_in;
        // a toggling input stays active until the timeout runs out
        if (level_in != st.prev) begin
            next_st.cnt = RELOAD;
        end else if (tick_in && st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
        end
        next_st.active = level_in | (next_st.cnt != '0);
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st <= wrc_pkg::ACT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign active_out = st.active;

endmodule

// ---- verilog/wrc_pin_ctrl.sv ----
// pin level control: wake, reset pin, direct inputs, sense select, fault flag
//
// Summary of operation
// - sense pin shows selected channel or temperature
// - sense pin tri-stated when setting asks it
// - any direct input activity wakes the device
// - each direct input switches its own output while its direct_en is set and pwm_en is clear
// - fault flag pulled low during any fault, except in sleep
// - fault details only on serial diagnostic path
// - wake pin high wakes the device
// - reset pin high also counts as wake
// - reset pin low clears setup, faults, watchdog run
// - reset pin rising edge starts the watchdog
// - no wake source means sleep, outputs off
// - fail-safe uses direct inputs, default setup
`timescale 1ns/1ns
module wrc_pin_ctrl #(
    parameter int unsigned TICK_CYC      = wrc_pkg::TICK_CYC,
    parameter int unsigned TIMEOUT_TICKS = wrc_pkg::T_IN_TICKS
) (
    // clock and system reset
    input  wire logic                clk_sys_in,
    input  wire logic                rst_in,
    // device pins
    input  wire logic                reset_pin_in,
    input  wire logic                wake_pin_in,
    input  wire logic [3:0]          direct_in,
    // serial port side: setting write and diagnostic clear
    input  wire logic                cfg_wr_in,
    input  wire wrc_pkg::wrc_cfg_t   cfg_in,
    input  wire logic                diag_clr_in,
    // internal sources
    input  wire logic                fail_in,
    input  wire wrc_pkg::wrc_fault_t fault_in,
    input  wire logic [3:0]          pwm_gate_in,
    // outputs to the switches and the pwm unit
    output logic [3:0]               power_out,
    output logic                     pwm_clk_out,
    // sense pin control
    output wrc_pkg::wrc_sense_t      load_sense_sel_out,
    output logic                     load_sense_oe_n_out,
    // fault flag pin, open drain
    output logic                     fault_flag_n_out,
    output logic                     fault_flag_n_oe_out,
    // status to the serial port and watchdog
    output wrc_pkg::wrc_fault_t      diag_out,
    output wrc_pkg::wrc_cfg_t        cfg_out,
    output wrc_pkg::wrc_mode_t       mode_out,
    output logic                     wdog_start_out,
    output logic                     wdog_run_out
);

    // refused at elaboration: the divider must fit its counter
    if (TICK_CYC < 2 || TICK_CYC >= (1 << wrc_pkg::TICK_W)) begin : g_bad_tick
        $error("wrc_pin_ctrl: TICK_CYC out of range");
    end

    localparam logic [wrc_pkg::TICK_W-1:0] TICK_LAST = wrc_pkg::TICK_W'(TICK_CYC - 1);

    wrc_pkg::wrc_state_t st;
    wrc_pkg::wrc_state_t next_st;
    logic [3:0]          in_active;
    logic                wake;
    logic                rst_low;
    logic                fault_any;
    logic [3:0]          drive;

    genvar g;
    generate
        for (g = 0; g < wrc_pkg::NUM_CH; g++) begin : g_act
            wrc_in_activity #(
                .TIMEOUT_TICKS (TIMEOUT_TICKS)
            ) u_act (
                .clk_sys_in (clk_sys_in),
                .rst_in     (rst_in),
                .tick_in    (st.tick),
                .level_in   (st.din_s2[g]),
                .active_out (in_active[g])
            );
        end
    endgenerate

    always_comb begin
        next_st = st;

        next_st.rst_s1  = reset_pin_in;
        next_st.rst_s2  = st.rst_s1;
        next_st.rst_s3  = st.rst_s2;
        next_st.wake_s1 = wake_pin_in;
        next_st.wake_s2 = st.wake_s1;
        next_st.din_s1  = direct_in;
        next_st.din_s2  = st.din_s1;

        // millisecond enable for the toggle timeout
        if (st.tick_cnt == TICK_LAST) begin
            next_st.tick_cnt = '0;
            next_st.tick     = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 1'b1;
            next_st.tick     = 1'b0;
        end

        // wake is or of all sources
        wake    = st.rst_s2 | st.wake_s2 | (|in_active);
        rst_low = ~st.rst_s2;

        // sleep only when no source wakes; reset pin low only clears
        if (!wake) begin
            next_st.mode = wrc_pkg::MODE_SLEEP;
        end else if (fail_in) begin
            next_st.mode = wrc_pkg::MODE_FAILSAFE;
        end else begin
            next_st.mode = wrc_pkg::MODE_NORMAL;
        end

        // setting held at default; writes only in normal mode
        if (rst_low || next_st.mode == wrc_pkg::MODE_FAILSAFE) begin
            next_st.cfg = wrc_pkg::CFG_RESET;
        end else if (cfg_wr_in) begin
            next_st.cfg = cfg_in;
        end

        // sticky faults; a new fault wins over a clear
        if (rst_low) begin
            next_st.faults = wrc_pkg::FAULT_RESET;
        end else if (diag_clr_in) begin
            next_st.faults = fault_in;
        end else begin
            next_st.faults = st.faults | fault_in;
        end

        drive = 4'h0;
        case (st.mode)
            wrc_pkg::MODE_SLEEP: begin
                drive = 4'h0;
            end
            wrc_pkg::MODE_FAILSAFE: begin
                drive = st.din_s2;
            end
            wrc_pkg::MODE_NORMAL: begin
                for (int i = 0; i < wrc_pkg::NUM_CH; i++) begin
                    if (st.cfg.pwm_en) begin
                        drive[i] = st.cfg.spi_on[i] & pwm_gate_in[i];
                    end else if (st.cfg.direct_en[i]) begin
                        drive[i] = st.din_s2[i];
                    end else begin
                        drive[i] = st.cfg.spi_on[i];
                    end
                end
                // input 0 may carry the pwm clock; its output still follows the gate
            end
            default: begin
                drive = 4'h0;
            end
        endcase
        next_st.power = drive;

        // external pwm clock taken from input 0
        next_st.pwm_clk = (st.mode == wrc_pkg::MODE_NORMAL) & st.cfg.pwm_en
                          & st.cfg.pwm_ext_clk & st.din_s2[wrc_pkg::PWM_CLK_CH];

        next_st.sense_sel.temp = st.cfg.sense_temp;
        next_st.sense_sel.chan = st.cfg.sense_chan;
        // sense tri-state, also released in sleep
        next_st.sense_oe_n = st.cfg.sense_hiz | (st.mode == wrc_pkg::MODE_SLEEP);

        // summary flag of live and latched faults
        fault_any = (|st.faults) | (|fault_in);
        next_st.flag_oe_n = ~(fault_any & (st.mode != wrc_pkg::MODE_SLEEP));

        // watchdog starts on reset pin rising edge
        next_st.wdog_start = st.rst_s2 & ~st.rst_s3;
        if (rst_low) begin
            next_st.wdog_run = 1'b0;
        end else if (next_st.wdog_start) begin
            next_st.wdog_run = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st <= wrc_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign power_out           = st.power;
    assign pwm_clk_out         = st.pwm_clk;
    assign load_sense_sel_out  = st.sense_sel;
    assign load_sense_oe_n_out = st.sense_oe_n;
    // open drain: only ever drives low
    assign fault_flag_n_out    = 1'b0;
    assign fault_flag_n_oe_out = st.flag_oe_n;
    // details only on the diagnostic word
    assign diag_out            = st.faults;
    assign cfg_out             = st.cfg;
    assign mode_out            = st.mode;
    assign wdog_start_out      = st.wdog_start;
    assign wdog_run_out        = st.wdog_run;

endmodule

// ---- bench/wrc_pin_ctrl_checker.sv ----
// port assertions of the pin control block
`timescale 1ns/1ns
module wrc_pin_ctrl_checker (
    // clock and reset
    input wire logic                clk_sys_in,
    input wire logic                rst_in,
    // inputs watched
    input wire logic                reset_pin_in,
    input wire logic [3:0]          direct_in,
    input wire logic [3:0]          pwm_gate_in,
    input wire wrc_pkg::wrc_fault_t fault_in,
    // outputs watched
    input wire logic [3:0]          power_out,
    input wire wrc_pkg::wrc_sense_t load_sense_sel_out,
    input wire logic                load_sense_oe_n_out,
    input wire logic                fault_flag_n_oe_out,
    input wire wrc_pkg::wrc_fault_t diag_out,
    input wire wrc_pkg::wrc_cfg_t   cfg_out,
    input wire wrc_pkg::wrc_mode_t  mode_out,
    input wire logic                wdog_start_out,
    input wire logic                wdog_run_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    property p_sense_oe;
        1 |=> load_sense_oe_n_out == $past(cfg_out.sense_hiz || mode_out == wrc_pkg::MODE_SLEEP);
    endproperty
    a_sense_oe: assert property (p_sense_oe) else $error("sense enable wrong");
    property p_sense_sel;
        1 |=> load_sense_sel_out == $past({cfg_out.sense_temp, cfg_out.sense_chan});
    endproperty
    a_sense_sel: assert property (p_sense_sel) else $error("sense source wrong");
    property p_wdog;
        $rose(reset_pin_in) |-> ##[1:5] wdog_start_out ##1 (!wdog_start_out && wdog_run_out);
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog start missing");
    property p_rpin;
        !reset_pin_in [*5] |-> cfg_out == wrc_pkg::CFG_RESET && diag_out == '0
            && !wdog_run_out && !wdog_start_out;
    endproperty
    a_rpin: assert property (p_rpin) else $error("reset pin not honoured");
    property p_drive;
        $past(mode_out) == wrc_pkg::MODE_NORMAL && mode_out == wrc_pkg::MODE_NORMAL |->
            power_out == ($past(cfg_out.pwm_en) ? $past(cfg_out.spi_on & pwm_gate_in)
            : ($past(cfg_out.direct_en) & $past(direct_in, 3)
            | ~$past(cfg_out.direct_en) & $past(cfg_out.spi_on)));
    endproperty
    a_drive: assert property (p_drive) else $error("normal drive wrong");
    property p_fsafe;
        $past(mode_out) == wrc_pkg::MODE_FAILSAFE && mode_out == wrc_pkg::MODE_FAILSAFE |->
            power_out == $past(direct_in, 3) && cfg_out == wrc_pkg::CFG_RESET;
    endproperty
    a_fsafe: assert property (p_fsafe) else $error("fail-safe drive wrong");
    property p_sleep;
        $past(mode_out) == wrc_pkg::MODE_SLEEP && mode_out == wrc_pkg::MODE_SLEEP |->
            power_out == 4'h0 && load_sense_oe_n_out && fault_flag_n_oe_out;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep outputs not off");
    property p_flag;
        (fault_in != '0 && mode_out != wrc_pkg::MODE_SLEEP) ##1 mode_out != wrc_pkg::MODE_SLEEP
            |-> !fault_flag_n_oe_out;
    endproperty
    a_flag: assert property (p_flag) else $error("fault flag not pulled");
    c_wdog: cover property (wdog_start_out);
    c_fsafe: cover property (mode_out == wrc_pkg::MODE_FAILSAFE);
    c_flag: cover property (!fault_flag_n_oe_out);
endmodule

// ---- bench/wrc_host.sv ----
// host model driving the control pins
`timescale 1ns/1ns
module wrc_host #(
    parameter int unsigned HOLD_CYC = wrc_pkg::T_WRST_CYC
) (
    input  wire logic clk_in,
    output logic      reset_pin_out = 1'b0,
    output logic      wake_out = 1'b0,
    output logic [3:0] direct_out = 4'h0
);
    // pin held low for the least time
    task automatic reset_pulse();
        reset_pin_out = 1'b0;
        repeat (HOLD_CYC) @(posedge clk_in);
        #1;
        reset_pin_out = 1'b1;
    endtask
    task automatic set_pins(input logic w, input logic [3:0] d);
        wake_out = w;
        direct_out = d;
    endtask
    // external pwm clock on input 0
    task automatic pwm_clock(input int n);
        repeat (n) begin
            repeat (2) @(posedge clk_in);
            #1;
            direct_out[0] = ~direct_out[0];
        end
    endtask
endmodule

// ---- bench/tb_wrc_pin_ctrl.sv ----
// self-checking bench of the pin control block
`timescale 1ns/1ns
module tb_wrc_pin_ctrl;
    logic                clk_sys_in = 1'b0;
    logic                rst_in = 1'b1;
    logic                cfg_wr_in = 1'b0;
    logic                diag_clr_in = 1'b0;
    logic                fail_in = 1'b0;
    logic [3:0]          pwm_gate_in = 4'h6;
    wrc_pkg::wrc_cfg_t   cfg_in = wrc_pkg::CFG_RESET;
    wrc_pkg::wrc_fault_t fault_in = '0;
    logic                reset_pin_in, wake_pin_in, pwm_clk_out, load_sense_oe_n_out;
    logic                fault_flag_n_out, fault_flag_n_oe_out, wdog_start_out, wdog_run_out;
    logic [3:0]          direct_in, power_out;
    wrc_pkg::wrc_sense_t load_sense_sel_out;
    wrc_pkg::wrc_fault_t diag_out;
    wrc_pkg::wrc_cfg_t   cfg_out;
    wrc_pkg::wrc_mode_t  mode_out;
    int                  n_fail = 0;
    int                  samples_checked = 0;
    always #25 clk_sys_in = ~clk_sys_in;
    // short time base keeps the run brief
    wrc_pin_ctrl #(.TICK_CYC(4), .TIMEOUT_TICKS(3)) dut (.*);
    wrc_host host (.clk_in(clk_sys_in), .reset_pin_out(reset_pin_in),
        .wake_out(wake_pin_in), .direct_out(direct_in));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wr_cfg(input wrc_pkg::wrc_cfg_t c);
        cfg_in = c;
        cfg_wr_in = 1'b1;
        cyc(1);
        cfg_wr_in = 1'b0;
        cyc(1);
    endtask
    task automatic t_wsrc();
        chk(16'(mode_out), 16'(wrc_pkg::MODE_SLEEP));
        host.set_pins(1'b1, 4'h0);
        cyc(3);
        chk(16'(mode_out), 16'(wrc_pkg::MODE_NORMAL));
        host.set_pins(1'b0, 4'h0);
        cyc(3);
        chk(16'(mode_out), 16'(wrc_pkg::MODE_SLEEP));
        host.set_pins(1'b0, 4'h2);
        cyc(4);
        chk(16'(mode_out), 16'(wrc_pkg::MODE_NORMAL));
        cyc(1);
        chk(16'(power_out), 16'h0002);
        host.set_pins(1'b0, 4'h0);
        cyc(8);
        chk(16'(mode_out), 16'(wrc_pkg::MODE_NORMAL));
        cyc(12);
        chk(16'(mode_out), 16'(wrc_pkg::MODE_SLEEP));
    endtask
    task automatic t_wake();
        host.set_pins(1'b0, 4'h0);
        host.reset_pulse();
        chk(16'(mode_out), 16'(wrc_pkg::MODE_SLEEP));
        chk(16'(power_out), 16'h0000);
        cyc(3);
        chk(16'(wdog_start_out), 16'h0001);
        cyc(1);
        chk(16'(wdog_start_out), 16'h0000);
        chk(16'(wdog_run_out), 16'h0001);
        chk(16'(mode_out), 16'(wrc_pkg::MODE_NORMAL));
    endtask
    task automatic t_direct();
        host.set_pins(1'b0, 4'ha);
        cyc(5);
        host.set_pins(1'b0, 4'h5);
        cyc(2);
        chk(16'(power_out), 16'h000a);
        cyc(1);
        chk(16'(power_out), 16'h0005);
    endtask
    task automatic t_sense();
        wrc_pkg::wrc_cfg_t c;
        c = wrc_pkg::CFG_RESET;
        c.sense_hiz = 1'b0;
        c.sense_temp = 1'b1;
        wr_cfg(c);
        chk(16'(load_sense_oe_n_out), 16'h0000);
        chk(16'(load_sense_sel_out), 16'h0004);
        c.sense_temp = 1'b0;
        for (int ch = 0; ch < 4; ch++) begin
            c.sense_chan = 2'(ch);
            wr_cfg(c);
            chk(16'(load_sense_sel_out), 16'(ch));
        end
        c.sense_hiz = 1'b1;
        c.pwm_en = 1'b1;
        c.pwm_ext_clk = 1'b1;
        c.spi_on = 4'h3;
        wr_cfg(c);
        chk(16'(load_sense_oe_n_out), 16'h0001);
        chk(16'(power_out), 16'h0002);
        host.pwm_clock(1);
        cyc(3);
        chk(16'(pwm_clk_out), 16'h0000);
        host.pwm_clock(1);
        cyc(3);
        chk(16'(pwm_clk_out), 16'h0001);
        chk(16'(power_out), 16'h0002);
    endtask
    task automatic t_fault();
        fault_in.oc[1] = 1'b1;
        cyc(1);
        fault_in = '0;
        cyc(2);
        chk(16'(fault_flag_n_oe_out), 16'h0000);
        chk(16'(diag_out), 16'h0800);
        diag_clr_in = 1'b1;
        cyc(1);
        diag_clr_in = 1'b0;
        cyc(2);
        chk(16'(fault_flag_n_oe_out), 16'h0001);
        // a fault in the clearing cycle must survive the clear
        fault_in.ov = 1'b1;
        diag_clr_in = 1'b1;
        cyc(1);
        fault_in = '0;
        diag_clr_in = 1'b0;
        chk(16'(diag_out), 16'h0001);
    endtask
    task automatic t_fail();
        fail_in = 1'b1;
        host.set_pins(1'b1, 4'h9);
        cyc(5);
        chk(16'(mode_out), 16'(wrc_pkg::MODE_FAILSAFE));
        chk(16'(power_out), 16'h0009);
        fail_in = 1'b0;
        cyc(5);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        cyc(3);
        rst_in = 1'b0;
        t_wsrc();
        t_wake();
        t_direct();
        t_sense();
        t_fault();
        t_wake();
        chk(16'(cfg_out), 16'(wrc_pkg::CFG_RESET));
        chk(16'(diag_out), 16'h0000);
        t_fail();
        test_done();
    end
endmodule
bind wrc_pin_ctrl wrc_pin_ctrl_checker chk_i (.*);
